// File: wdt_checker.sv
// Purpose: port-level checks of the watchdog block
// Assumes: config inputs only change while reset is held
// Notes:   bound into wdt_top at the foot of this file
module wdt_checker
#(
   parameter int CNT_W = 32
)
(
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        config_enable_in,
   input wire logic [4:0]  config_postscale_setting_in,
   input wire logic        sleep_idle_in,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        device_reset_out,
   input wire logic        wake_out,
   input wire logic        irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        rd_r;
   logic        rel_r;
   logic [11:0] a_r;
   logic [4:0]  ps_r;
   // ***************************************************************
   // read data phase tracking
   // ***************************************************************
   always_ff @(posedge clk_in)
   begin
      rd_r  <= !sys_rst_in && hsel && hready && htrans[1] && !hwrite;
      a_r   <= haddr[11:0];
      rel_r <= sys_rst_in;
      if (rel_r && !sys_rst_in)
      begin
         ps_r <= config_postscale_setting_in;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ***************************************************************
   // assertions
   // ***************************************************************
   hready_high_a: assert property (hreadyout)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not okay");
   idle_data_a: assert property (!rd_r |-> hrdata == 32'h0)
      else $error("hrdata outside read phase");
   unimpl_zero_a: assert property (rd_r && a_r == 12'h000 |->
      hrdata[31:16] == 16'h0 && hrdata[14:7] == 8'h00 && !hrdata[0])
      else $error("control reserved bits set");
   shadow_load_a: assert property (rd_r && a_r == 12'h000 |->
      hrdata[6:2] == ps_r) else $error("postscale shadow wrong");
   cfg_on_a: assert property (rd_r && a_r == 12'h000 &&
      config_enable_in |-> hrdata[15]) else $error("enable reads zero");
   unmap_zero_a: assert property (rd_r && a_r == 12'h00C |->
      hrdata == 32'h0) else $error("unmapped read not zero");
   rst_pulse_a: assert property ($rose(device_reset_out) |->
      device_reset_out[*8] ##1 !device_reset_out)
      else $error("reset pulse length wrong");
   wake_cause_a: assert property ($rose(wake_out) |->
      $past(sleep_idle_in)) else $error("wake without sleep");
   wake_clear_a: assert property (!sleep_idle_in |=> !wake_out)
      else $error("wake held after sleep");
   cover property ($rose(device_reset_out));
   cover property ($rose(wake_out));
   cover property ($rose(irq_out));
endmodule

bind wdt_top wdt_checker #(.CNT_W(CNT_W)) u_chk (.clk_in, .sys_rst_in,
   .config_enable_in, .config_postscale_setting_in, .sleep_idle_in, .hsel,
   .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .device_reset_out, .wake_out, .irq_out);

// File: wdt_low_power_rc_clock_sync.sv
// Purpose: brings low_power_rc_clock edges into the system clock domain
// Assumes: the oscillator runs much slower than clk_in
// Notes:   emits one pulse per rising edge of the oscillator
module wdt_low_power_rc_clock_sync
(
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic low_power_rc_clock_in,
   output logic      tick_out
);

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } wdt_sync_st_t;

   wdt_sync_st_t st_r;
   wdt_sync_st_t st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = low_power_rc_clock_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // edge taken only between the second and third stage
   assign tick_out = st_r.s2 & ~st_r.s3;

endmodule

// File: wdt_pkg.sv
// Purpose: types shared by the watchdog files
// Assumes: nothing beyond the register header
// Notes:   no imports; users write wdt_pkg::name
package wdt_pkg;

   typedef enum logic [1:0]
   {
      WDT_IDLE  = 2'b00,
      WDT_RUN   = 2'b01,
      WDT_RESET = 2'b10
   } wdt_state_t;

   typedef struct packed
   {
      logic       on;
      logic [4:0] postscale;
      logic       win_en;
   } wdt_ctrl_t;

   typedef struct packed
   {
      logic expire;
      logic win_fault;
      logic wake;
   } wdt_evt_t;

endpackage

// File: wdt_regs.svh
// Purpose: register offsets, field positions and reset values of the watchdog
// Assumes: one aligned 32-bit word per register on AHB-Lite
// Notes:   included by bare name; definitions only
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define WDT_CTRL_OFS      12'h000
`define WDT_STAT_OFS      12'h004
`define WDT_MASK_OFS      12'h008
`define WDT_CFG_OFS       12'h00C

// ***************************************************************
// control register fields
// ***************************************************************
`define WDT_ON_BIT        15
`define WDT_PS_LSB        2
`define WDT_PS_MSB        6
`define WDT_WIN_BIT       1
`define WDT_CLR_BIT       0

// ***************************************************************
// status and mask fields
// ***************************************************************
`define WDT_EV_EXPIRE     0
`define WDT_EV_WINFAULT   1
`define WDT_EV_WAKE       2
`define WDT_EV_W          3

// ***************************************************************
// reset values and timing
// ***************************************************************
`define WDT_CTRL_RST      32'h0000_0000
`define WDT_MASK_RST      3'h0
`define WDT_RST_PULSE_CYC 4'h8
`define WDT_SYNC_STAGES   2

`endif

// File: wdt_tb_top.sv
// Purpose: self-checking bench of the watchdog block
// Assumes: oscillator input toggles every 5 clocks, one tick per 10
// Notes:   period in clocks is 10 times 2 to the postscale
module wdt_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, sys_rst_in = 1, low_power_rc_clock_in = 0;
   logic config_enable_in = 0, sleep_idle_in = 0, hsel = 0, hwrite = 0;
   logic [4:0]  config_postscale_setting_in = 5'h02, p;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, seed = 32'h3DCD2142;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic hreadyout, hresp, device_reset_out, wake_out, irq_out;
   int n_mismatch = 0, checked = 0, cyc = 0, rst_cnt = 0, lpc = 0;
   int t, k, n0;
   wdt_top DUT (.clk_in, .sys_rst_in, .low_power_rc_clock_in,
      .config_enable_in, .config_postscale_setting_in, .sleep_idle_in,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .device_reset_out, .wake_out, .irq_out);
   always #10 clk_in = ~clk_in;
   // ***************************************************************
   // oscillator, reset watch and hang limit
   // ***************************************************************
   always @(posedge clk_in)
   begin
      cyc++;
      lpc = (lpc == 9) ? 0 : lpc + 1;
      low_power_rc_clock_in <= (lpc < 5);
      if (device_reset_out === 1'b1) rst_cnt++;
      if (cyc > 60000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // expected control word from the rule bit positions
   function automatic logic [31:0] ctrl_exp(input logic on, win);
      ctrl_exp = 32'h0000_0000;
      ctrl_exp[15] = on;
      ctrl_exp[6:2] = p;
      ctrl_exp[1] = win;
   endfunction
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d);
      @(posedge clk_in); // idle gap before every transfer
      hsel <= 1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rdc(input logic [31:0] a, exp);
      ahb(0, a, 0);
      chk(r, exp);
   endtask
   task automatic do_reset(input logic ce);
      seed = xs(seed);
      p = 5'h02 + 5'(seed % 3);
      t = 10 << p;
      @(posedge clk_in);
      sys_rst_in <= 1;
      config_enable_in <= ce;
      config_postscale_setting_in <= p;
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 0;
   endtask
   // waits for reset or wake, k is the cycles spent
   task automatic wait_out(input int n);
      for (k = 0; k < n; k++)
      begin
         @(posedge clk_in);
         if (device_reset_out === 1'b1 || wake_out === 1'b1) break;
      end
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      do_reset(0);
      rdc(0, ctrl_exp(0, 0));
      seed = xs(seed);
      ahb(1, 0, (seed & 32'hFFFF7FFE) | 32'h2);
      rdc(0, ctrl_exp(0, 1));
      ahb(1, 12'h00C, seed);
      rdc(12'h00C, 0);
      ahb(1, 8, 0);
      ahb(1, 0, 32'h8000);
      rdc(0, ctrl_exp(1, 0));
      wait_out(2 * t + 40);
      chk(k > t - 30 && k < t + 20, 1);
      ahb(1, 0, 0);
      ahb(0, 4, 0);
      chk(r[0], 1);
      chk(irq_out, 0);
      ahb(1, 8, 1);
      repeat (2) @(posedge clk_in);
      chk(irq_out, 1);
      ahb(1, 4, 7);
      rdc(4, 0);
      chk(irq_out, 0);
      n0 = rst_cnt;
      ahb(1, 0, 32'h8000);
      repeat (6)
      begin
         repeat (t / 2) @(posedge clk_in);
         ahb(1, 0, 32'h8001);
      end
      chk(rst_cnt - n0, 0);
      ahb(1, 0, 32'h8002);
      ahb(1, 0, 32'h8003);
      wait_out(40);
      chk(k < 40, 1);
      ahb(1, 0, 0);
      ahb(0, 4, 0);
      chk(r[1], 1);
      ahb(1, 4, 7);
      sleep_idle_in <= 1;
      n0 = rst_cnt;
      ahb(1, 0, 32'h8000);
      wait_out(2 * t + 40);
      chk(wake_out, 1);
      chk(rst_cnt - n0, 0);
      ahb(1, 0, 0);
      ahb(0, 4, 0);
      chk(r[2], 1);
      sleep_idle_in <= 0;
      repeat (2) @(posedge clk_in);
      chk(wake_out, 0);
      do_reset(1);
      rdc(0, ctrl_exp(1, 0));
      ahb(1, 0, 0);
      rdc(0, ctrl_exp(1, 0));
      final_report();
   end
endmodule

// File: wdt_top.sv
// Purpose: windowed watchdog timer with AHB-Lite register slave
// Assumes: single word transfers; low_power_rc_clock slower than clk_in
// Notes:   counter advances only on oscillator ticks
//
// Summary of operation
// - count advances from low-power oscillator ticks, not the system clock
// - unserviced expiry forces a whole-device reset
// - postscale setting selects time-out length as power of two ticks
// - expiry in sleep or idle raises wake instead of being lost
// - enable bit 15 starts watchdog; zero stops only software enable
// - enable bit reads one when running from config or software
// - postscale shadow bits 6:2 reload from config at every reset
// - bit 1 selects windowed mode, resets to zero
// - writing one to bit 0 restarts the count, or forces reset if before the window in windowed mode; zero does nothing
// - bits 31:16 and 14:7 read zero, writes ignored
`include "wdt_regs.svh"

module wdt_top
#(
   parameter int CNT_W = 32
)
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        low_power_rc_clock_in,
   input  wire logic        config_enable_in,
   input  wire logic [4:0]  config_postscale_setting_in,
   input  wire logic        sleep_idle_in,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             device_reset_out,
   output logic             wake_out,
   output logic             irq_out
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed
   {
      wdt_pkg::wdt_state_t fsm;
      logic                sw_on;
      logic                win_en;
      logic [4:0]          postscale;
      logic [CNT_W-1:0]    count;
      logic [3:0]          rst_cnt;
      logic                wake;
      logic [2:0]          status;
      logic [2:0]          mask;
      logic                dp_wr;
      logic [11:0]         dp_addr;
      logic [31:0]         rdata;
      logic                cfg_seen;
   } wdt_st_t;

   wdt_st_t st_r;
   wdt_st_t st_nxt;

   logic             tick;
   logic             running;
   logic             ap_valid;
   logic             wr_ctrl;
   logic             wr_stat;
   logic             wr_mask;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] win_open;
   logic             expire;
   logic             clr_req;
   logic             early;
   logic             in_run;
   logic [2:0]       ev_vec;
   logic [2:0]       stat_next;
   wdt_pkg::wdt_evt_t ev;

   // ***************************************************************
   // oscillator edge detect
   // ***************************************************************
   wdt_low_power_rc_clock_sync u_sync
   (
      .clk_in                (clk_in),
      .sys_rst_in            (sys_rst_in),
      .low_power_rc_clock_in (low_power_rc_clock_in),
      .tick_out              (tick)
   );

   // ***************************************************************
   // bus decode
   // ***************************************************************
   assign ap_valid = hsel & hready & htrans[1];
   assign wr_ctrl  = st_r.dp_wr & (st_r.dp_addr == `WDT_CTRL_OFS);
   assign wr_stat  = st_r.dp_wr & (st_r.dp_addr == `WDT_STAT_OFS);
   assign wr_mask  = st_r.dp_wr & (st_r.dp_addr == `WDT_MASK_OFS);

   // ***************************************************************
   // timing
   // ***************************************************************
   assign running  = config_enable_in | st_r.sw_on;
   // period is 2^postscale ticks; postscale of CNT_W or more saturates
   // compare in int width: a 5-bit cast of CNT_W would wrap to zero
   assign period   = (int'(st_r.postscale) >= CNT_W) ? '1 :
                     ((CNT_W)'(1) << st_r.postscale);
   // window opens for the last quarter of the period
   assign win_open = period - (period >> 2);
   // only a running counter may expire or fault; idle and reset hold zero
   assign in_run   = (st_r.fsm == wdt_pkg::WDT_RUN);
   assign expire   = in_run & running & tick
                     & (st_r.count >= period - 1'b1);
   assign clr_req  = wr_ctrl & hwdata[`WDT_CLR_BIT];
   assign early    = clr_req & in_run & running & st_r.win_en
                     & (st_r.count < win_open);

   // a restart in the expiry cycle wins, so no expiry is flagged then
   assign ev.expire    = expire & ~clr_req;
   assign ev.win_fault = early;
   assign ev.wake      = expire & ~clr_req & sleep_idle_in;

   // ***************************************************************
   // status bits
   // ***************************************************************
   // bit order comes from the register map, not from the struct order
   assign ev_vec[`WDT_EV_EXPIRE]   = ev.expire;
   assign ev_vec[`WDT_EV_WINFAULT] = ev.win_fault;
   assign ev_vec[`WDT_EV_WAKE]     = ev.wake;

   // write one clears; a new event in the same cycle wins
   genvar g;
   generate
      for (g = 0; g < `WDT_EV_W; g++)
      begin : g_stat
         assign stat_next[g] = ev_vec[g]
                               | (st_r.status[g] & ~(wr_stat & hwdata[g]));
      end
   endgenerate

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.dp_wr = 1'b0;
      if (ap_valid)
      begin
         st_nxt.dp_wr   = hwrite;
         st_nxt.dp_addr = haddr[11:0];
      end

      // reload shadow once after each reset release
      if (!st_r.cfg_seen)
      begin
         st_nxt.postscale = config_postscale_setting_in;
         st_nxt.cfg_seen  = 1'b1;
      end

      if (wr_ctrl)
      begin
         // only on and window bits are writable
         st_nxt.sw_on  = hwdata[`WDT_ON_BIT];
         st_nxt.win_en = hwdata[`WDT_WIN_BIT];
      end
      if (wr_mask)
         st_nxt.mask = hwdata[2:0];

      case (st_r.fsm)
         wdt_pkg::WDT_IDLE:
         begin
            st_nxt.count = '0;
            if (running)
               st_nxt.fsm = wdt_pkg::WDT_RUN;
         end
         wdt_pkg::WDT_RUN:
         begin
            if (!running)
            begin
               st_nxt.fsm   = wdt_pkg::WDT_IDLE;
               st_nxt.count = '0;
            end
            else if (early)
            begin
               st_nxt.fsm     = wdt_pkg::WDT_RESET;
               st_nxt.rst_cnt = `WDT_RST_PULSE_CYC;
            end
            else if (clr_req)
               st_nxt.count = '0;
            else if (expire)
            begin
               st_nxt.count = '0;
               if (sleep_idle_in)
                  st_nxt.wake = 1'b1;
               else
               begin
                  st_nxt.fsm     = wdt_pkg::WDT_RESET;
                  st_nxt.rst_cnt = `WDT_RST_PULSE_CYC;
               end
            end
            else if (tick)
               st_nxt.count = st_r.count + 1'b1;
         end
         wdt_pkg::WDT_RESET:
         begin
            st_nxt.count = '0;
            if (st_r.rst_cnt == 4'h1)
               st_nxt.fsm = wdt_pkg::WDT_IDLE;
            st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
         end
         default:
            st_nxt.fsm = wdt_pkg::WDT_IDLE;
      endcase

      // wake holds until core leaves sleep or idle
      if (!sleep_idle_in)
         st_nxt.wake = 1'b0;

      st_nxt.status = stat_next;

      // read data captured at the address phase
      st_nxt.rdata = 32'h0000_0000;
      if (ap_valid && !hwrite)
      begin
         case (haddr[11:0])
            `WDT_CTRL_OFS:
            begin
               st_nxt.rdata[`WDT_ON_BIT] = running;
               st_nxt.rdata[`WDT_PS_MSB:`WDT_PS_LSB] = st_r.postscale;
               st_nxt.rdata[`WDT_WIN_BIT] = st_r.win_en;
            end
            `WDT_STAT_OFS: st_nxt.rdata[2:0] = st_r.status;
            `WDT_MASK_OFS: st_nxt.rdata[2:0] = st_r.mask;
            default:       st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         st_r           <= '0;
         st_r.fsm       <= wdt_pkg::WDT_IDLE;
         st_r.mask      <= `WDT_MASK_RST;
      end
      else
         st_r <= st_nxt;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign hrdata           = st_r.rdata;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign device_reset_out = (st_r.fsm == wdt_pkg::WDT_RESET);
   assign wake_out         = st_r.wake;
   assign irq_out          = |(st_r.status & st_r.mask);

endmodule
